// File: hdl/esil_defs.svh
// Constants for the external and shared interrupt request logic
`ifndef ESIL_DEFS_SVH
`define ESIL_DEFS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define ESIL_ADDR_W        12
`define ESIL_DATA_W        32
`define ESIL_NUM_FLAGS     15
`define ESIL_SHARED_GROUPS 7

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ESIL_ADDR_CTRL   12'h000
`define ESIL_ADDR_ENABLE 12'h004
`define ESIL_ADDR_FLAGS  12'h008
`define ESIL_ADDR_STATUS 12'h00c

// ****************************************************************
// Control register fields
// ****************************************************************
`define ESIL_C_GIE      0
`define ESIL_C_HALL_LO  1
`define ESIL_C_HALL_HI  2
`define ESIL_C_EXT_LO   3
`define ESIL_C_EXT_HI   4
`define ESIL_C_FILT_LO  5
`define ESIL_C_FILT_HI  6
`define ESIL_CTRL_W     7
`define ESIL_CTRL_RST   7'h00

// ****************************************************************
// Flag and enable bit positions (same layout in both registers)
// ****************************************************************
`define ESIL_F_HALLG 0
`define ESIL_F_HALLA 1
`define ESIL_F_HALLB 2
`define ESIL_F_HALLC 3
`define ESIL_F_EXT   4
`define ESIL_F_FILT  5
`define ESIL_F_COMP  6
`define ESIL_F_CAPO  7
`define ESIL_F_CAPC  8
`define ESIL_F_GRP1  9
`define ESIL_F_GRP2  10
`define ESIL_F_GRP3  11
`define ESIL_F_GRP4  12
`define ESIL_F_GRP5  13
`define ESIL_F_GRP6  14
`define ESIL_FLAGS_RST  15'h0000
`define ESIL_ENABLE_RST 15'h0000

// ****************************************************************
// Status register fields
// ****************************************************************
`define ESIL_S_REQ    0
`define ESIL_S_VEC_LO 4
`define ESIL_S_VEC_HI 7

// ****************************************************************
// Edge select codes
// ****************************************************************
`define ESIL_EDGE_OFF  2'h0
`define ESIL_EDGE_RISE 2'h1
`define ESIL_EDGE_FALL 2'h2
`define ESIL_EDGE_BOTH 2'h3

`endif

// File: hdl/esil_pkg.sv
// Types for the external and shared interrupt request logic
`include "esil_defs.svh"

package esil_pkg;

  // ****************************************************************
  // Vectors, in priority order, lowest code first
  // ****************************************************************
  typedef enum logic [3:0] {
    ESIL_VEC_HALL = 4'h0,
    ESIL_VEC_EXT  = 4'h1,
    ESIL_VEC_FILT = 4'h2,
    ESIL_VEC_COMP = 4'h3,
    ESIL_VEC_GRP1 = 4'h4,
    ESIL_VEC_GRP2 = 4'h5,
    ESIL_VEC_GRP3 = 4'h6,
    ESIL_VEC_GRP4 = 4'h7,
    ESIL_VEC_GRP5 = 4'h8,
    ESIL_VEC_GRP6 = 4'h9
  } esil_vec_type;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [`ESIL_ADDR_W-1:0]  paddr;
    logic [`ESIL_DATA_W-1:0]  pwdata;
  } esil_apb_req_type;

  typedef struct packed {
    logic [`ESIL_DATA_W-1:0]  prdata;
    logic                     pready;
    logic                     pslverr;
  } esil_apb_rsp_type;

  typedef struct packed {
    logic hall_input_a;
    logic hall_input_b;
    logic hall_input_c;
    logic ext_irq_pin;
    logic filtered_input_pin;
    logic comparator_zero_out;
  } esil_pins_type;

  typedef struct packed {
    logic         irq_req;
    esil_vec_type irq_vector;
  } esil_core_req_type;

  // ****************************************************************
  // Whole module state
  // ****************************************************************
  typedef struct packed {
    esil_pins_type              sync1;
    esil_pins_type              sync2;
    esil_pins_type              prev;
    logic [`ESIL_CTRL_W-1:0]    ctrl;
    logic [`ESIL_NUM_FLAGS-1:0] enable;
    logic [`ESIL_NUM_FLAGS-1:0] flags;
    esil_core_req_type          core;
    logic                       wake;
    esil_apb_rsp_type           apb;
  } esil_state_type;

endpackage : esil_pkg

// File: hdl/esil_irq_logic.sv
// Edge interrupts, comparator and capture interrupts and shared groups
`timescale 1ns/1ps
`include "esil_defs.svh"

module esil_irq_logic #(
  parameter int SHARED_GROUPS = `ESIL_SHARED_GROUPS
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire esil_pkg::esil_apb_req_type apb_req,
  output      esil_pkg::esil_apb_rsp_type apb_rsp,
  input  wire esil_pkg::esil_pins_type    pins,
  input  wire logic                       capture_overflow_irq,
  input  wire logic                       capture_compare_irq,
  input  wire logic [4:0]                 shared_src_event,
  input  wire logic                       stack_full,
  input  wire logic                       irq_ack,
  output      esil_pkg::esil_core_req_type core_req,
  output      logic                       wake_pulse
);
  import esil_pkg::*;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  generate
    if (SHARED_GROUPS != `ESIL_SHARED_GROUPS) begin : g_bad_groups
      $error("esil_irq_logic serves exactly seven shared groups");
    end
  endgenerate

  // ****************************************************************
  // Edge detector
  // ****************************************************************
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
    logic hit;
    hit = 1'b0;
    case (sel)
      `ESIL_EDGE_RISE: hit = cur & ~prv;
      `ESIL_EDGE_FALL: hit = ~cur & prv;
      `ESIL_EDGE_BOTH: hit = cur ^ prv;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  esil_state_type             state;
  esil_state_type             next_state;
  logic [`ESIL_NUM_FLAGS-1:0] setv;
  logic [`ESIL_NUM_FLAGS-1:0] clr;
  logic [`ESIL_NUM_FLAGS-1:0] f;
  logic [`ESIL_NUM_FLAGS-1:0] en;
  logic [9:0]                 pend;
  logic                       taken;
  logic                       access;
  logic                       wr;
  logic                       mapped;
  logic [`ESIL_DATA_W-1:0]    rdata;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    f          = state.flags;
    en         = state.enable;
    // Pin synchronisers; first stage is read only by the second
    next_state.sync1 = pins;
    next_state.sync2 = state.sync1;
    next_state.prev  = state.sync2;

    // Source events
    setv = '0;
    setv[`ESIL_F_HALLA] = edge_hit(state.ctrl[`ESIL_C_HALL_HI:`ESIL_C_HALL_LO],
                                   state.sync2.hall_input_a, state.prev.hall_input_a);
    setv[`ESIL_F_HALLB] = edge_hit(state.ctrl[`ESIL_C_HALL_HI:`ESIL_C_HALL_LO],
                                   state.sync2.hall_input_b, state.prev.hall_input_b);
    setv[`ESIL_F_HALLC] = edge_hit(state.ctrl[`ESIL_C_HALL_HI:`ESIL_C_HALL_LO],
                                   state.sync2.hall_input_c, state.prev.hall_input_c);
    setv[`ESIL_F_HALLG] = setv[`ESIL_F_HALLA] | setv[`ESIL_F_HALLB] | setv[`ESIL_F_HALLC];
    setv[`ESIL_F_EXT]   = edge_hit(state.ctrl[`ESIL_C_EXT_HI:`ESIL_C_EXT_LO],
                                   state.sync2.ext_irq_pin, state.prev.ext_irq_pin);
    setv[`ESIL_F_FILT]  = edge_hit(state.ctrl[`ESIL_C_FILT_HI:`ESIL_C_FILT_LO],
                                   state.sync2.filtered_input_pin,
                                   state.prev.filtered_input_pin);
    setv[`ESIL_F_COMP]  = state.sync2.comparator_zero_out
                          ^ state.prev.comparator_zero_out;
    setv[`ESIL_F_CAPO]  = capture_overflow_irq;
    setv[`ESIL_F_CAPC]  = capture_compare_irq;
    setv[`ESIL_F_GRP1]  = capture_overflow_irq | capture_compare_irq;
    setv[`ESIL_F_GRP6:`ESIL_F_GRP2] = shared_src_event;

    // Pending requests, index equals vector code
    pend    = '0;
    pend[0] = f[`ESIL_F_HALLG] & en[`ESIL_F_HALLG]
              & |(f[`ESIL_F_HALLC:`ESIL_F_HALLA] & en[`ESIL_F_HALLC:`ESIL_F_HALLA]);
    pend[1] = f[`ESIL_F_EXT] & en[`ESIL_F_EXT];
    pend[2] = f[`ESIL_F_FILT] & en[`ESIL_F_FILT];
    pend[3] = f[`ESIL_F_COMP] & en[`ESIL_F_COMP];
    pend[4] = f[`ESIL_F_GRP1] & en[`ESIL_F_GRP1]
              & ((f[`ESIL_F_CAPO] & en[`ESIL_F_CAPO])
                 | (f[`ESIL_F_CAPC] & en[`ESIL_F_CAPC]));
    pend[9:5] = f[`ESIL_F_GRP6:`ESIL_F_GRP2] & en[`ESIL_F_GRP6:`ESIL_F_GRP2];

    // Service by the core
    taken = irq_ack & state.core.irq_req;
    clr   = '0;
    if (taken) begin
      case (state.core.irq_vector)
        ESIL_VEC_HALL: clr[`ESIL_F_HALLG] = 1'b1;
        ESIL_VEC_EXT:  clr[`ESIL_F_EXT]   = 1'b1;
        ESIL_VEC_FILT: clr[`ESIL_F_FILT]  = 1'b1;
        ESIL_VEC_COMP: clr[`ESIL_F_COMP]  = 1'b1;
        ESIL_VEC_GRP1: clr[`ESIL_F_GRP1]  = 1'b1;
        ESIL_VEC_GRP2: clr[`ESIL_F_GRP2]  = 1'b1;
        ESIL_VEC_GRP3: clr[`ESIL_F_GRP3]  = 1'b1;
        ESIL_VEC_GRP4: clr[`ESIL_F_GRP4]  = 1'b1;
        ESIL_VEC_GRP5: clr[`ESIL_F_GRP5]  = 1'b1;
        ESIL_VEC_GRP6: clr[`ESIL_F_GRP6]  = 1'b1;
        default:       clr = '0;
      endcase
    end

    // APB slave, one wait state then pready
    access = apb_req.psel & apb_req.penable;
    mapped = (apb_req.paddr == `ESIL_ADDR_CTRL) | (apb_req.paddr == `ESIL_ADDR_ENABLE)
             | (apb_req.paddr == `ESIL_ADDR_FLAGS) | (apb_req.paddr == `ESIL_ADDR_STATUS);
    wr     = access & state.apb.pready & apb_req.pwrite & mapped;
    rdata  = '0;
    case (apb_req.paddr)
      `ESIL_ADDR_CTRL:   rdata[`ESIL_CTRL_W-1:0]    = state.ctrl;
      `ESIL_ADDR_ENABLE: rdata[`ESIL_NUM_FLAGS-1:0] = state.enable;
      `ESIL_ADDR_FLAGS:  rdata[`ESIL_NUM_FLAGS-1:0] = state.flags;
      `ESIL_ADDR_STATUS: begin
        rdata[`ESIL_S_REQ]                  = state.core.irq_req;
        rdata[`ESIL_S_VEC_HI:`ESIL_S_VEC_LO] = state.core.irq_vector;
      end
      default:           rdata = '0;
    endcase
    next_state.apb.pready  = access & ~state.apb.pready;
    next_state.apb.pslverr = access & ~state.apb.pready & ~mapped;
    next_state.apb.prdata  = (access & ~state.apb.pready & ~apb_req.pwrite) ? rdata : '0;
    if (wr && apb_req.paddr == `ESIL_ADDR_CTRL) begin
      next_state.ctrl = apb_req.pwdata[`ESIL_CTRL_W-1:0];
    end
    if (wr && apb_req.paddr == `ESIL_ADDR_ENABLE) begin
      next_state.enable = apb_req.pwdata[`ESIL_NUM_FLAGS-1:0];
    end
    if (wr && apb_req.paddr == `ESIL_ADDR_FLAGS) begin
      clr = clr | apb_req.pwdata[`ESIL_NUM_FLAGS-1:0];
    end
    if (taken) begin
      next_state.ctrl[`ESIL_C_GIE] = 1'b0;
    end

    // Flags record whatever the enables; set wins over clear
    next_state.flags = (state.flags & ~clr) | setv;
    next_state.wake  = |(setv & ~state.flags);

    // Request towards the core, lowest priority first so the lowest pending code wins
    next_state.core.irq_req    = state.ctrl[`ESIL_C_GIE] & ~stack_full & (|pend)
                                 & ~taken;
    next_state.core.irq_vector = ESIL_VEC_HALL;
    for (int i = 9; i >= 0; i--) begin
      if (pend[i]) begin
        next_state.core.irq_vector = esil_vec_type'(4'(i));
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= '0;
      state.ctrl   <= `ESIL_CTRL_RST;
      state.enable <= `ESIL_ENABLE_RST;
      state.flags  <= `ESIL_FLAGS_RST;
    end else begin
      state <= next_state;
    end
  end

  assign apb_rsp    = state.apb;
  assign core_req   = state.core;
  assign wake_pulse = state.wake;

endmodule : esil_irq_logic

// File: tb/esil_irq_logic_sva.sv
// Port assertions for the interrupt request logic
`timescale 1ns/1ps
module esil_irq_sva #(
  parameter int SHARED_GROUPS = 7
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire esil_pkg::esil_apb_req_type  apb_req,
  input wire esil_pkg::esil_apb_rsp_type  apb_rsp,
  input wire esil_pkg::esil_pins_type     pins,
  input wire logic                        capture_overflow_irq,
  input wire logic                        capture_compare_irq,
  input wire logic [4:0]                  shared_src_event,
  input wire logic                        stack_full,
  input wire logic                        irq_ack,
  input wire esil_pkg::esil_core_req_type core_req,
  input wire logic                        wake_pulse
);
  import esil_pkg::*;
  logic mapped;
  assign mapped = apb_req.paddr[11:4] == 8'h00 && apb_req.paddr[1:0] == 2'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_taken;
    core_req.irq_req && irq_ack;
  endsequence
  AST_WAIT_STATE: assert property (s_setup |=> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  AST_ERR_DECODE: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
    else $error("pslverr wrong for address");
  AST_ERR_QUAL: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  AST_DATA_IDLE: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
    else $error("prdata not zero when idle");
  AST_FULL_BLOCK: assert property (stack_full |=> !core_req.irq_req)
    else $error("request while stack full");
  AST_ACK_CLEAR: assert property (s_taken |=> !core_req.irq_req [*3])
    else $error("request did not drop after ack");
  AST_REQ_HOLD: assert property (core_req.irq_req && !irq_ack && !stack_full
    && !apb_req.psel |=> core_req.irq_req)
    else $error("pending request lost");
endmodule : esil_irq_sva

bind esil_irq_logic esil_irq_sva #(.SHARED_GROUPS(SHARED_GROUPS)) u_sva (
  .pclk, .presetn, .apb_req, .apb_rsp, .pins, .capture_overflow_irq, .capture_compare_irq,
  .shared_src_event, .stack_full, .irq_ack, .core_req, .wake_pulse
);

// File: tb/esil_core_model.sv
// Core sequencer model that takes interrupt vectors
`timescale 1ns/1ps
module esil_core_model (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire esil_pkg::esil_core_req_type core_req,
  input  wire logic                        slow,
  input  wire logic                        full,
  output      logic                        irq_ack,
  output      logic                        stack_full
);
  import esil_pkg::*;
  logic [1:0] wait_cnt;
  assign stack_full = full;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      irq_ack <= 1'b0;
      if (core_req.irq_req && !irq_ack && !full) begin
        if (!slow || wait_cnt == 2'h3) begin
          irq_ack  <= 1'b1;
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end else begin
        wait_cnt <= 2'h0;
      end
    end
  end
endmodule : esil_core_model

// File: tb/test_esil_irq_logic.sv
// Self-checking bench for the interrupt request logic
`timescale 1ns/1ps
module test_esil_irq_logic;
  import esil_pkg::*;
  esil_apb_req_type  req;
  esil_apb_rsp_type  rsp;
  esil_pins_type     pins;
  esil_core_req_type creq;
  logic              pclk, presetn, cov, ccmp, ack, sfull, slow, full, wake;
  logic [4:0]        shev;
  logic [33:0]       aq[$];
  logic [3:0]        vq[$];
  logic [33:0]       e;
  logic [31:0]       rnd;
  int                bad_count, total_checks, cyc, wakes;
  esil_irq_logic dut (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp), .pins,
    .capture_overflow_irq(cov), .capture_compare_irq(ccmp), .shared_src_event(shev),
    .stack_full(sfull), .irq_ack(ack), .core_req(creq), .wake_pulse(wake));
  esil_core_model core (.pclk, .presetn, .core_req(creq), .slow, .full, .irq_ack(ack),
    .stack_full(sfull));
  always #4 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    aq.push_back({w, x});
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    req <= '0;
  endtask : apb
  always @(posedge pclk) begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (rsp.pready === 1'b1) begin
      e = aq.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, rsp.pslverr});
      if (!e[33]) chk("prdata", e[31:0], rsp.prdata);
    end
    if (creq.irq_req === 1'b1 && ack === 1'b1) begin
      chk("irq_vector", {28'h0, vq.pop_front()}, {28'h0, creq.irq_vector});
    end
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    pins = '0;
    {cov, ccmp, slow, full} = 4'h0;
    shev = 5'h0;
    bad_count = 0;
    total_checks = 0;
    cyc = 0;
    wakes = 0;
    rnd = 32'h92c1e88e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i += 4) apb(0, 12'(i), 0, 33'h0);
    apb(0, 12'h010, 0, {1'b1, 32'h0});
    apb(1, 12'h014, 32'h1, {1'b1, 32'h0});
    apb(1, 12'h00c, 32'hffff_ffff, 33'h0);
    apb(0, 12'h00c, 0, 33'h0);
    rnd = xs(rnd);
    apb(1, 12'h004, rnd, 33'h0);
    apb(0, 12'h004, 0, {18'h0, rnd[14:0]});
    chk("wake_pulse", 0, wakes);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      apb(1, 12'h000, {25'h0, c[1:0], c[1:0], c[1:0], 1'b0}, 33'h0);
      for (int f = 0; f < 2; f++) begin
        apb(1, 12'h008, 32'h7fff, 33'h0);
        pins <= f ? '0 : '1;
        repeat (4) @(posedge pclk);
        apb(0, 12'h008, 0, {26'h0, c[f] ? 7'h7f : 7'h40});
        chk("wake_pulse", 2 * c + f + 1, wakes);
      end
    end
    $display("test edges done");
    apb(1, 12'h004, 32'h7fff, 33'h0);
    for (int v = 0; v < 4; v++) begin
      vq.push_back(v[3:0]);
      apb(1, 12'h000, 32'h7f, 33'h0);
      @(posedge pclk iff (creq.irq_req === 1'b1 && ack === 1'b1));
    end
    apb(0, 12'h008, 0, 33'h000e);
    chk("wake_pulse", 8, wakes);
    $display("test vectors done");
    apb(1, 12'h008, 32'h7fff, 33'h0);
    full <= 1'b1;
    slow <= 1'b1;
    {cov, ccmp} <= 2'h3;
    shev <= 5'h1f;
    @(posedge pclk);
    {cov, ccmp} <= 2'h0;
    shev <= 5'h0;
    apb(1, 12'h000, 32'h7f, 33'h0);
    repeat (8) @(posedge pclk);
    apb(0, 12'h008, 0, 33'h7f80);
    chk("wake_pulse", 9, wakes);
    for (int v = 4; v < 10; v++) begin
      vq.push_back(v[3:0]);
      if (v == 4) full <= 1'b0;
      else apb(1, 12'h000, 32'h7f, 33'h0);
      @(posedge pclk iff (creq.irq_req === 1'b1 && ack === 1'b1));
    end
    apb(0, 12'h008, 0, 33'h0180);
    $display("test shared done");
    end_sim();
  end
endmodule : test_esil_irq_logic
